// [hdl/ucs_pkg.sv]
package ucs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode configuration field layout
  localparam int MODE_W     = 16;
  localparam int LEN_LSB    = 0;
  localparam int CLKSRC_LSB = 4;
  localparam int SYNC_BIT   = 7;
  localparam int PAR_LSB    = 8;
  localparam int STOP_LSB   = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Field encodings
  localparam logic [2:0] LEN_MAX    = 3'h4;
  localparam logic [3:0] MIN_DATA   = 4'h5;
  localparam logic [3:0] MAX_DATA   = 4'h9;
  localparam logic [1:0] PAR_NONE   = 2'h2;
  localparam logic [1:0] PAR_MDROP  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts
  localparam int PRE_DIV      = 8;
  localparam int OVERSAMPLE   = 16;
  localparam int START_LOW    = 7;
  localparam int FIRST_SAMPLE = 24;
  localparam int TIMEOUT_MULT = 4;

endpackage

// [hdl/ucs_baud_gen.sv]
`timescale 1ns/1ns
module ucs_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // Configuration
  input  wire logic             i_sync_mode,
  input  wire logic [1:0]       i_clk_src,
  input  wire logic [DIV_W-1:0] i_divider_value,
  // External link clock
  input  wire logic             i_link_clk,
  // Enables
  output logic                  o_samp_en,
  output logic                  o_bit_rise,
  output logic                  o_bit_fall
);

  logic [2:0]       pre_q;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             ext_s3_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [3:0]       sub_q;

  ////////////////////////////////////////////////////////////////////////////
  // Source select and divider
  wire ext_sel    = i_clk_src[1];
  wire ext_rise   = ext_s2_q & ~ext_s3_q;
  wire ext_fall   = ~ext_s2_q & ext_s3_q;
  wire pre_tick   = (pre_q == 3'(ucs_pkg::PRE_DIV - 1));
  wire src_en     = ext_sel ? ext_rise : (i_clk_src[0] ? pre_tick : 1'b1);
  wire div_zero   = (i_divider_value == '0);
  wire div_wrap   = src_en && !div_zero && (div_cnt_q >= i_divider_value - 1'b1);
  wire div_half   = src_en && !div_zero && (div_cnt_q == (i_divider_value >> 1));
  wire ext_direct = i_sync_mode && ext_sel;
  wire sub_wrap   = o_samp_en && (sub_q == 4'(ucs_pkg::OVERSAMPLE - 1));

  assign o_samp_en  = !i_sync_mode && div_wrap;
  // Async rate is source / (16 * divider); sync takes divider or the pin
  assign o_bit_rise = ext_direct ? ext_rise : (i_sync_mode ? div_wrap : sub_wrap);
  assign o_bit_fall = ext_direct ? ext_fall : (i_sync_mode ? div_half : sub_wrap);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pre_q    <= '0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      div_cnt_q <= '0;
      sub_q    <= '0;
    end else begin
      pre_q    <= pre_tick ? 3'h0 : pre_q + 3'h1;
      ext_s1_q <= i_link_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (div_zero) begin
        div_cnt_q <= '0;
      end else if (src_en) begin
        div_cnt_q <= div_wrap ? '0 : div_cnt_q + 1'b1;
      end
      if (o_samp_en) begin
        sub_q <= sub_wrap ? 4'h0 : sub_q + 4'h1;
      end
    end
  end

  property p_div_off;
    @(posedge i_core_clk) disable iff (i_rst)
    div_zero && !ext_direct |-> !o_samp_en && !o_bit_rise;
  endproperty
  a_div_off: assert property (p_div_off) else $error("bit clock runs with zero divider");

  property p_ext_direct;
    @(posedge i_core_clk) disable iff (i_rst)
    ext_direct && $rose(ext_s2_q) |-> o_bit_rise;
  endproperty
  a_ext_direct: assert property (p_ext_direct) else $error("pin edge not used");

endmodule

// [hdl/ucs_core.sv]
`timescale 1ns/1ns
module ucs_core #(
  parameter int DIV_W = 16,
  parameter int TO_W  = 16,
  parameter int GAP_W = 8
) (
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  // Configuration
  input  wire logic [ucs_pkg::MODE_W-1:0] i_mode_cfg,
  input  wire logic [DIV_W-1:0]           i_divider_value,
  input  wire logic [TO_W-1:0]            i_idle_timeout_value,
  input  wire logic [GAP_W-1:0]           i_gap_length_value,
  // Commands
  input  wire logic                       i_clear_status,
  input  wire logic                       i_restart_idle_wait,
  input  wire logic                       i_send_address,
  // Transmit holding
  input  wire logic                       i_thr_write,
  input  wire logic [8:0]                 i_thr_data,
  // Receive holding
  input  wire logic                       i_rhr_read,
  // Line
  input  wire logic                       i_link_clk,
  input  wire logic                       i_rxd,
  output logic                            o_txd,
  // Status
  output logic [8:0]                      o_rhr_data,
  output logic                            o_rx_ready,
  output logic                            o_overrun,
  output logic                            o_check_err,
  output logic                            o_stop_err,
  output logic                            o_idle_expired,
  output logic                            o_tx_ready,
  output logic                            o_tx_empty
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ucs_rx_state_type;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_GUARD} ucs_tx_state_type;

  localparam logic [4:0] START_LAST = 5'(ucs_pkg::START_LOW - 1);
  localparam logic [4:0] FIRST_WAIT = 5'(ucs_pkg::FIRST_SAMPLE - ucs_pkg::START_LOW);
  localparam logic [4:0] BIT_WAIT   = 5'(ucs_pkg::OVERSAMPLE);
  localparam int         TO_CNT_W   = TO_W + $clog2(ucs_pkg::TIMEOUT_MULT);

  ucs_rx_state_type    rx_state_q;
  ucs_tx_state_type    tx_state_q;
  logic [4:0]          rx_cnt_q;
  logic [3:0]          rx_idx_q;
  logic [10:0]         rx_bits_q;
  logic                to_armed_q;
  logic [TO_CNT_W-1:0] to_cnt_q;
  logic [8:0]          thr_q;
  logic                thr_full_q;
  logic                thr_addr_q;
  logic                addr_pend_q;
  logic [12:0]         tx_sh_q;
  logic [3:0]          tx_left_q;
  logic [GAP_W-1:0]    gap_cnt_q;
  logic [12:0]         tx_frame;
  logic                samp_en;
  logic                bit_rise;
  logic                bit_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire       sync_mode = i_mode_cfg[ucs_pkg::SYNC_BIT];
  wire [1:0] clk_src   = i_mode_cfg[ucs_pkg::CLKSRC_LSB +: 2];
  wire [2:0] len_code  = i_mode_cfg[ucs_pkg::LEN_LSB +: 3];
  wire [2:0] par_kind  = i_mode_cfg[ucs_pkg::PAR_LSB +: 3];
  wire       two_stop  = |i_mode_cfg[ucs_pkg::STOP_LSB +: 2];
  wire       par_none  = (par_kind[2:1] == ucs_pkg::PAR_NONE);
  wire       multidrop = (par_kind[2:1] == ucs_pkg::PAR_MDROP);
  wire       has_par   = !par_none;

  // Lengths above nine clamp to nine
  wire [3:0] n_data    = (len_code >= ucs_pkg::LEN_MAX) ? ucs_pkg::MAX_DATA
                         : {1'b0, len_code} + ucs_pkg::MIN_DATA;
  wire [8:0] data_mask = 9'h1ff >> (ucs_pkg::MAX_DATA - n_data);
  wire [3:0] n_rx      = n_data + {3'h0, has_par} + 4'h1;
  wire [3:0] n_tx      = n_data + {3'h0, has_par} + (two_stop ? 4'h3 : 4'h2);

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock generation
  ucs_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_sync_mode     (sync_mode),
    .i_clk_src       (clk_src),
    .i_divider_value (i_divider_value),
    .i_link_clk      (i_link_clk),
    .o_samp_en       (samp_en),
    .o_bit_rise      (bit_rise),
    .o_bit_fall      (bit_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  wire       rx_hunt = sync_mode ? bit_rise : samp_en;
  wire       rx_samp = (rx_state_q == RX_BITS) &&
                       (sync_mode ? bit_rise : (samp_en && rx_cnt_q == 5'h1));
  wire       rx_last = rx_samp && (rx_idx_q == n_rx - 4'h1);
  wire [8:0] rx_data = rx_bits_q[8:0] & data_mask;
  wire       rx_par  = rx_bits_q[n_data];
  wire       rx_calc = par_kind[1] ? par_kind[0] : (^rx_data ^ par_kind[0]);
  wire       par_bad = multidrop ? rx_par : (has_par && rx_par != rx_calc);
  wire       stop_bad = !i_rxd && |rx_data;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= '0;
      rx_idx_q   <= '0;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: begin
          if (rx_hunt && !i_rxd) begin
            rx_state_q <= sync_mode ? RX_BITS : RX_START;
            rx_cnt_q   <= '0;
            rx_idx_q   <= '0;
          end
        end
        RX_START: begin
          if (samp_en) begin
            if (i_rxd) begin
              rx_state_q <= RX_IDLE;
            end else if (rx_cnt_q == START_LAST) begin
              rx_state_q <= RX_BITS;
              rx_cnt_q   <= FIRST_WAIT;
            end else begin
              rx_cnt_q <= rx_cnt_q + 5'h1;
            end
          end
        end
        RX_BITS: begin
          if (samp_en) begin
            rx_cnt_q <= (rx_cnt_q == 5'h1) ? BIT_WAIT : rx_cnt_q - 5'h1;
          end
          if (rx_samp) begin
            rx_idx_q <= rx_idx_q + 4'h1;
          end
          if (rx_last) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_bits_q <= '0;
    end else if (rx_samp) begin
      rx_bits_q[rx_idx_q] <= i_rxd;
    end
  end

  // Status: a new event in the same cycle as a clear wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rhr_data  <= '0;
      o_rx_ready  <= 1'b0;
      o_overrun   <= 1'b0;
      o_check_err <= 1'b0;
      o_stop_err  <= 1'b0;
    end else begin
      if (rx_last) begin
        o_rhr_data <= rx_data;
      end
      o_rx_ready  <= rx_last | (o_rx_ready & ~i_rhr_read);
      o_overrun   <= (rx_last & o_rx_ready & ~i_rhr_read)
                     | (o_overrun & ~i_clear_status);
      o_check_err <= (rx_last & par_bad) | (o_check_err & ~i_clear_status);
      o_stop_err  <= (rx_last & stop_bad) | (o_stop_err & ~i_clear_status);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle time-out
  wire to_off = (i_idle_timeout_value == '0);
  wire to_hit = to_armed_q && bit_rise && (to_cnt_q == TO_CNT_W'(1));

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      to_armed_q <= 1'b0;
      to_cnt_q   <= '0;
    end else if (to_off || to_hit || i_restart_idle_wait) begin
      to_armed_q <= 1'b0;
    end else if (rx_last) begin
      to_armed_q <= 1'b1;
      to_cnt_q   <= TO_CNT_W'(i_idle_timeout_value) * TO_CNT_W'(ucs_pkg::TIMEOUT_MULT);
    end else if (to_armed_q && bit_rise) begin
      to_cnt_q <= to_cnt_q - TO_CNT_W'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_idle_expired <= 1'b0;
    end else begin
      o_idle_expired <= to_hit | (o_idle_expired & ~i_restart_idle_wait);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  wire [8:0] tx_data = thr_q & data_mask;
  wire       tx_calc = par_kind[1] ? par_kind[0] : (^tx_data ^ par_kind[0]);
  wire       tx_par  = multidrop ? thr_addr_q : tx_calc;
  wire       tx_done = (tx_state_q == TX_SHIFT) && (tx_left_q == 4'h0);
  wire       gap_on  = (i_gap_length_value != '0);
  wire       tx_slot = (tx_state_q == TX_IDLE) || (tx_done && !gap_on) ||
                       ((tx_state_q == TX_GUARD) && gap_cnt_q == GAP_W'(1));
  wire       tx_start = bit_fall && thr_full_q && tx_slot;

  always_comb begin
    tx_frame    = '1;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n_data) begin
        tx_frame[i + 1] = tx_data[i];
      end
    end
    if (has_par) begin
      tx_frame[n_data + 4'h1] = tx_par;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      thr_q       <= '0;
      thr_full_q  <= 1'b0;
      thr_addr_q  <= 1'b0;
      addr_pend_q <= 1'b0;
    end else begin
      if (i_thr_write) begin
        thr_q      <= i_thr_data;
        thr_addr_q <= addr_pend_q | i_send_address;
      end
      thr_full_q  <= i_thr_write | (thr_full_q & ~tx_start);
      addr_pend_q <= i_send_address | (addr_pend_q & ~i_thr_write);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= '1;
      tx_left_q  <= '0;
      gap_cnt_q  <= '0;
      o_txd      <= 1'b1;
    end else if (tx_start) begin
      tx_state_q <= TX_SHIFT;
      o_txd      <= tx_frame[0];
      tx_sh_q    <= {1'b1, tx_frame[12:1]};
      tx_left_q  <= n_tx - 4'h1;
    end else if (bit_fall) begin
      unique case (tx_state_q)
        TX_IDLE: o_txd <= 1'b1;
        TX_SHIFT: begin
          if (tx_done) begin
            tx_state_q <= gap_on ? TX_GUARD : TX_IDLE;
            gap_cnt_q  <= i_gap_length_value;
          end else begin
            o_txd     <= tx_sh_q[0];
            tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
            tx_left_q <= tx_left_q - 4'h1;
          end
        end
        TX_GUARD: begin
          o_txd     <= 1'b1;
          gap_cnt_q <= gap_cnt_q - GAP_W'(1);
          if (gap_cnt_q == GAP_W'(1)) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  assign o_tx_ready = !thr_full_q;
  assign o_tx_empty = (tx_state_q == TX_IDLE) && !thr_full_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rx_ready;
    @(posedge i_core_clk) disable iff (i_rst)
    rx_last |=> o_rx_ready && o_rhr_data == $past(rx_data);
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("character not delivered");

  property p_overrun;
    @(posedge i_core_clk) disable iff (i_rst)
    rx_last && o_rx_ready && !i_rhr_read |=> o_overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_mdrop;
    @(posedge i_core_clk) disable iff (i_rst)
    rx_last && multidrop && !o_check_err |=> o_check_err == $past(rx_par);
  endproperty
  a_mdrop: assert property (p_mdrop) else $error("address flag wrong");

  property p_stop;
    @(posedge i_core_clk) disable iff (i_rst)
    rx_last && !i_rxd && (rx_data != 9'h0) |=> o_stop_err;
  endproperty
  a_stop: assert property (p_stop) else $error("stop error missed");

  property p_clear;
    @(posedge i_core_clk) disable iff (i_rst)
    i_clear_status && !rx_last |=> !o_check_err && !o_overrun;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");

  property p_short_low;
    @(posedge i_core_clk) disable iff (i_rst)
    rx_state_q == RX_START && samp_en && i_rxd |=> rx_state_q == RX_IDLE;
  endproperty
  a_short_low: assert property (p_short_low) else $error("glitch taken as start");

  property p_start_bit;
    @(posedge i_core_clk) disable iff (i_rst)
    tx_start |=> !o_txd && tx_state_q == TX_SHIFT;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");

  property p_guard;
    @(posedge i_core_clk) disable iff (i_rst)
    tx_state_q == TX_GUARD || tx_state_q == TX_IDLE |-> o_txd;
  endproperty
  a_guard: assert property (p_guard) else $error("line low between characters");

  property p_empty;
    @(posedge i_core_clk) disable iff (i_rst)
    o_tx_empty |-> o_tx_ready && o_txd;
  endproperty
  a_empty: assert property (p_empty) else $error("empty while busy");

  property p_timeout;
    @(posedge i_core_clk) disable iff (i_rst)
    to_hit |=> o_idle_expired && !to_armed_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("idle expiry lost");

  c_rx_char: cover property (@(posedge i_core_clk) disable iff (i_rst) rx_last);
  c_tx_char: cover property (@(posedge i_core_clk) disable iff (i_rst) tx_start);
  c_idle_hit: cover property (@(posedge i_core_clk) disable iff (i_rst) to_hit);
  c_guard: cover property (@(posedge i_core_clk) disable iff (i_rst)
                           tx_state_q == TX_GUARD);

endmodule

// [dv/ucs_line_model.sv]
`timescale 1ns/1ns
module ucs_line_model (
  // Clock
  input  wire logic i_core_clk,
  // Line
  input  wire logic i_txd,
  output logic      o_rxd
);
  int          bit_cyc   = 16;
  int          frame_len = 11;
  logic [31:0] rx_q[$];
  longint      t_q[$];

  initial o_rxd = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Start of lo cycles, then n bits LSB first; a short lo makes a false start
  task automatic send(input logic [31:0] v, input int n, input int lo);
    @(posedge i_core_clk);
    o_rxd <= 1'b0;
    repeat (lo) @(posedge i_core_clk);
    for (int i = 0; i < n; i++) begin
      o_rxd <= v[i];
      repeat (bit_cyc) @(posedge i_core_clk);
    end
    o_rxd <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // No wait after the stop sample, so a start that follows directly is seen
  always begin : capture
    logic [31:0] v;
    @(negedge i_txd);
    t_q.push_back($time);
    v = '0;
    repeat (bit_cyc / 2) @(posedge i_core_clk);
    for (int i = 0; i < frame_len; i++) begin
      v[i] = i_txd;
      if (i < frame_len - 1) repeat (bit_cyc) @(posedge i_core_clk);
    end
    rx_q.push_back(v);
  end
endmodule

// [dv/ucs_core_test.sv]
`timescale 1ns/1ns
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module ucs_core_test;
  logic        i_core_clk, i_rst, i_link_clk, i_rxd, o_txd;
  logic        i_clear_status, i_restart_idle_wait, i_send_address, i_thr_write, i_rhr_read;
  logic [15:0] i_mode_cfg, i_divider_value, i_idle_timeout_value;
  logic [7:0]  i_gap_length_value, v;
  logic [8:0]  i_thr_data, o_rhr_data;
  logic        o_rx_ready, o_overrun, o_check_err, o_stop_err;
  logic        o_idle_expired, o_tx_ready, o_tx_empty;
  logic [31:0] e, f, exp_q[$];
  longint      t;
  int          par, n, stp, src, fail_count, compares;
  int          seed = 32'h35c8a397;
  int          codes[6] = '{0, 1, 2, 3, 4, 6};
  // Source code lands on mode bits 7:4: 2 link pin, 8 sync internal, 10 sync link pin
  int          srcs[6] = '{0, 1, 2, 8, 10, 0};
  int          divs[6] = '{2, 1, 1, 4, 0, 1};
  int          gaps[6] = '{0, 2, 1, 2, 1, 3};
  // Bit period in core cycles: async 16 * divider * source period, sync divider or pin
  int          bcyc[6] = '{32, 128, 128, 4, 8, 16};

  ucs_core ucs_core_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_mode_cfg(i_mode_cfg),
    .i_divider_value(i_divider_value), .i_idle_timeout_value(i_idle_timeout_value),
    .i_gap_length_value(i_gap_length_value), .i_clear_status(i_clear_status),
    .i_restart_idle_wait(i_restart_idle_wait), .i_send_address(i_send_address),
    .i_thr_write(i_thr_write), .i_thr_data(i_thr_data), .i_rhr_read(i_rhr_read),
    .i_link_clk(i_link_clk), .i_rxd(i_rxd), .o_txd(o_txd), .o_rhr_data(o_rhr_data),
    .o_rx_ready(o_rx_ready), .o_overrun(o_overrun), .o_check_err(o_check_err),
    .o_stop_err(o_stop_err), .o_idle_expired(o_idle_expired), .o_tx_ready(o_tx_ready),
    .o_tx_empty(o_tx_empty)
  );
  ucs_line_model ucs_line_model_inst (.i_core_clk(i_core_clk), .i_txd(o_txd), .o_rxd(i_rxd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask

  // Strobe k: 0 clear status, 1 restart idle wait, 2 send address, 3 read, 4 write
  task automatic pulse(input int k, input logic [8:0] d = 9'h0);
    @(posedge i_core_clk);
    {i_thr_write, i_rhr_read, i_send_address, i_restart_idle_wait, i_clear_status} <= 5'(1 << k);
    i_thr_data <= d;
    @(posedge i_core_clk);
    {i_thr_write, i_rhr_read, i_send_address, i_restart_idle_wait, i_clear_status} <= 5'h0;
    #1;
  endtask

  task automatic set_mode();
    @(posedge i_core_clk);
    i_mode_cfg <= 16'(n - 5) | 16'(src << 4) | 16'(par << 8) | 16'(stp << 12);
    #1;
  endtask

  function automatic logic exp_chk(input logic [8:0] d, input int addr);
    logic p;
    p = ^(d & 9'((1 << n) - 1));
    case (par)
      0: return p;
      1: return ~p;
      2: return 1'b0;
      3: return 1'b1;
      default: return 1'(addr);
    endcase
  endfunction

  // Writing waits for a free holding register: a write while full overwrites
  task automatic tx_one(input logic [8:0] d, input int addr);
    int pos;
    for (int i = 0; i < 3000 && o_tx_ready !== 1'b1; i++) cyc(1);
    e = (32'(d) & ((32'h1 << n) - 32'h1)) << 1;
    pos = n + 1;
    if (par != 4) begin
      e[pos] = exp_chk(d, addr);
      pos++;
    end
    e = e | ((stp ? 32'h3 : 32'h1) << pos);
    ucs_line_model_inst.frame_len = pos + (stp ? 2 : 1);
    exp_q.push_back(e);
    pulse(4, d);
    `CHECK("tx empty", 1'b0, o_tx_empty)
    `CHECK("tx ready", 1'b0, o_tx_ready)
  endtask

  task automatic drain();
    for (int i = 0; i < 6000 && ucs_line_model_inst.rx_q.size() < exp_q.size(); i++) cyc(1);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      f = ucs_line_model_inst.rx_q.size() > 0 ? ucs_line_model_inst.rx_q.pop_front() : 'x;
      `CHECK("tx frame", e, f)
    end
  endtask

  task automatic rx_one(input logic [7:0] d, input logic pb, input logic sb, input logic ce,
                        input logic se);
    ucs_line_model_inst.send(32'({sb, pb, d}), 10, ucs_line_model_inst.bit_cyc);
    cyc(3);
    `CHECK("rx ready", 1'b1, o_rx_ready)
    `CHECK("rx data", {1'b0, d}, o_rhr_data)
    `CHECK("check err", ce, o_check_err)
    `CHECK("stop err", se, o_stop_err)
  endtask

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // Link clock at one eighth of the core clock, each level four core cycles
  initial begin
    i_link_clk = 1'b0;
    forever begin
      repeat (4) @(posedge i_core_clk);
      i_link_clk <= ~i_link_clk;
    end
  end

  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end

  initial begin
    i_rst = 1'b1;
    {i_thr_write, i_rhr_read, i_send_address, i_restart_idle_wait, i_clear_status} = 5'h0;
    i_thr_data = 9'h0;
    i_mode_cfg = 16'h0003;
    i_divider_value = 16'h1;
    i_idle_timeout_value = 16'h0;
    i_gap_length_value = 8'h0;
    n = 8;
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    cyc(1);
    `CHECK("idle txd", 1'b1, o_txd)
    `CHECK("reset empty", 1'b1, o_tx_empty)
    foreach (codes[k]) begin
      par = codes[k];
      n = 5 + k % 5;
      stp = k % 2;
      set_mode();
      if (par == 6) pulse(2);
      tx_one(9'($random(seed)), par == 6);
      if (par == 6) tx_one(9'($random(seed)), 0);
      drain();
    end
    {par, n, stp} = {32'd0, 32'd8, 32'd0};
    set_mode();
    @(posedge i_core_clk);
    i_divider_value <= 16'h0;
    tx_one(9'h0a5, 0);
    cyc(400);
    `CHECK("stopped txd", 1'b1, o_txd)
    `CHECK("held char", 1'b0, o_tx_ready)
    for (int c = 0; c < 6; c++) begin
      src = srcs[c];
      ucs_line_model_inst.bit_cyc = bcyc[c];
      @(posedge i_core_clk);
      i_divider_value <= 16'(divs[c]);
      i_gap_length_value <= 8'(gaps[c]);
      set_mode();
      if (c == 0) drain();
      ucs_line_model_inst.t_q.delete();
      tx_one(9'($random(seed)), 0);
      tx_one(9'($random(seed)), 0);
      drain();
      t = ucs_line_model_inst.t_q[1] - ucs_line_model_inst.t_q[0];
      `CHECK("spacing", longint'((11 + gaps[c]) * ucs_line_model_inst.bit_cyc * 8), t)
      cyc(ucs_line_model_inst.bit_cyc * (gaps[c] + 1));
      `CHECK("done empty", 1'b1, o_tx_empty)
    end
    v = 8'($random(seed));
    rx_one(v, ^v, 1'b1, 1'b0, 1'b0);
    pulse(3);
    `CHECK("read ready", 1'b0, o_rx_ready)
    rx_one(v, ~^v, 1'b1, 1'b1, 1'b0);
    `CHECK("no overrun", 1'b0, o_overrun)
    rx_one(v, ^v, 1'b1, 1'b1, 1'b0);
    `CHECK("overrun", 1'b1, o_overrun)
    pulse(0);
    `CHECK("cleared err", 1'b0, o_check_err)
    pulse(3);
    rx_one(v | 8'h01, ^(v | 8'h01), 1'b0, 1'b0, 1'b1);
    pulse(0);
    pulse(3);
    ucs_line_model_inst.send(32'h0, 0, 7);
    cyc(300);
    `CHECK("glitch", 1'b0, o_rx_ready)
    `CHECK("no timeout", 1'b0, o_idle_expired)
    par = 6;
    set_mode();
    rx_one(v, 1'b1, 1'b1, 1'b1, 1'b0);
    pulse(0);
    pulse(3);
    rx_one(v, 1'b0, 1'b1, 1'b0, 1'b0);
    pulse(3);
    @(posedge i_core_clk);
    i_idle_timeout_value <= 16'h1;
    rx_one(v, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(30);
    `CHECK("early idle", 1'b0, o_idle_expired)
    cyc(70);
    `CHECK("idle", 1'b1, o_idle_expired)
    pulse(1);
    `CHECK("restart", 1'b0, o_idle_expired)
    cyc(200);
    `CHECK("rearmed", 1'b0, o_idle_expired)
    @(posedge i_core_clk);
    i_divider_value <= 16'h4;
    ucs_line_model_inst.bit_cyc = 4;
    src = 8;
    set_mode();
    rx_one(~v, 1'b1, 1'b1, 1'b1, 1'b0);
    end_of_test();
  end
endmodule
